/* File: include/otm_pkg.sv */
package otm_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SPEED1 = 8'h08;
  localparam logic [7:0] OFF_SPEED2 = 8'h0c;
  localparam logic [7:0] OFF_SETP0 = 8'h10;
  localparam logic [7:0] OFF_OPTIONS = 8'h24;
  localparam logic [7:0] OFF_ADJUST = 8'h28;
  localparam logic [7:0] OFF_EXACT = 8'h2c;
  localparam logic [7:0] OFF_PASSWORD = 8'h30;
  localparam logic [7:0] OFF_TRIM = 8'h34;
  // Control bits.
  localparam int CTRL_RESET = 0;
  localparam int CTRL_SAVE = 1;
  localparam int CTRL_CFG_ENTER = 2;
  localparam int CTRL_CFG_EXIT = 3;
  // Adjust and exact fields.
  localparam int ADJ_UP = 0;
  localparam int ADJ_DOWN = 1;
  localparam int ADJ_FAST = 2;
  localparam int SEL_LSB = 16;
  // Setpoint slots.
  localparam int SP_NUM = 5;
  localparam logic [2:0] SP_OVS = 3'h0;
  localparam logic [2:0] SP_FAIL = 3'h1;
  localparam logic [2:0] SP_TEETH1 = 3'h2;
  localparam logic [2:0] SP_TEETH2 = 3'h3;
  localparam logic [2:0] SP_WINDOW = 3'h4;
  localparam logic [15:0] RST_OVS = 16'h1f40;
  localparam logic [15:0] RST_FAIL = 16'h0190;
  localparam logic [15:0] RST_TEETH = 16'h001e;
  localparam logic [15:0] RST_WINDOW = 16'h00c8;
  localparam logic [1:0] RST_OPTIONS = 2'h3;
  localparam int OPT_TRIP_BOTH = 0;
  localparam int OPT_DIFF_EN = 1;
  localparam logic [15:0] STEP_SLOW = 16'h0001;
  localparam logic [15:0] STEP_FAST = 16'h000a;
  localparam logic [15:0] TRIM_MAX = 16'h0064;
  // Timing.
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int GATE_MS = 100;
  localparam int FLASH_MS = 250;
  localparam int PW_MIN = 30;
  localparam int PW_MS = PW_MIN * 60 * 1000;
  localparam int RESTART_CYCLES = 8;
  typedef enum logic [1:0] {MODE_RUN, MODE_CFG, MODE_STORE, MODE_RESTART} otm_mode_e;
endpackage

/* File: hw/otm_top.sv */
// What this block does
// - Overspeed opens the trip relay and flashes both alarm lamps.
// - Overspeed trip latches until reset arrives with speed below trip setpoint.
// - Both pickups count as failed when each reads below the fail setpoint.
// - Dual pickup failure opens the trip relay and lights both lamps steadily.
// - Dual failure alarms clear only while the failsafe override is closed.
// - Either pickup lost opens both pickup-failed relays and lights both lamps.
// - A pickup-failed alarm ignores reset until that pickup's signal returns or the override is closed.
// - Speed difference beyond window raises the alarm of the higher signal.
// - A missing pickup signal counts as the other pickup reading higher.
// - Configuration mode is entered on command; all outputs shut down one cycle later.
// - Leaving configuration stores all setpoints and then restarts the block.
// - Save copies setpoints to nonvolatile store; unsaved edits revert on restart.
// - A typed exact setpoint is taken only within ten percent of present value.
// - Fast adjust steps ten times the slow adjust step.
// - Correct password opens protected items for thirty minutes.
// - Terminal attach or detach never disturbs protection.
// - Closed override input disables the speed failsafe function.
// - Trip relay energized with no trip; opens on overspeed or dual failure.
module otm_top #(
  parameter int TICK_CYCLES = otm_pkg::TICK_CYCLES,
  parameter int PW_MS = otm_pkg::PW_MS,
  parameter int GATE_MS = otm_pkg::GATE_MS,
  parameter logic [15:0] PASSWORD = 16'h0123 // Arbitrary value.
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic speed_pickup1,
  input wire logic speed_pickup2,
  input wire logic reset_in,
  input wire logic override_in,
  input wire logic terminal_present,
  output logic trip_relay,
  output logic fail1_relay,
  output logic fail2_relay,
  output logic lamp1,
  output logic lamp2
);
  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [15:0] rpm_calc(input logic [15:0] pulses, input logic [15:0] teeth);
    logic [47:0] num;
    logic [47:0] den;
    num = 48'(pulses) * 48'd60000;
    den = 48'(teeth) * 48'(GATE_MS);
    rpm_calc = (den == 48'h0) ? 16'h0 : 16'((num / den) > 48'hffff ? 48'hffff : num / den);
  endfunction
  function automatic logic within_ten(input logic [15:0] v, input logic [15:0] cur);
    logic [19:0] d;
    d = (v > cur) ? 20'(v - cur) : 20'(cur - v);
    within_ten = (d * 20'd10) <= 20'(cur);
  endfunction
  // ----------------------------------------------------------------------
  // Input synchronisers and tick divider
  // ----------------------------------------------------------------------
  logic [1:0] pu1_s_r, pu2_s_r, rst_s_r, ovr_s_r, term_s_r;
  logic pu1_d_r, pu2_d_r, rst_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu1_s_r <= 2'h0;
      pu2_s_r <= 2'h0;
      rst_s_r <= 2'h0;
      ovr_s_r <= 2'h0;
      term_s_r <= 2'h0;
      pu1_d_r <= 1'b0;
      pu2_d_r <= 1'b0;
      rst_d_r <= 1'b0;
    end else begin
      pu1_s_r <= {pu1_s_r[0], speed_pickup1};
      pu2_s_r <= {pu2_s_r[0], speed_pickup2};
      rst_s_r <= {rst_s_r[0], reset_in};
      ovr_s_r <= {ovr_s_r[0], override_in};
      term_s_r <= {term_s_r[0], terminal_present};
      pu1_d_r <= pu1_s_r[1];
      pu2_d_r <= pu2_s_r[1];
      rst_d_r <= rst_s_r[1];
    end
  end
  wire logic pu1_edge = pu1_s_r[1] & ~pu1_d_r;
  wire logic pu2_edge = pu2_s_r[1] & ~pu2_d_r;
  wire logic override = ovr_s_r[1];
  logic [31:0] tick_cnt_r;
  logic tick_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end
  // ----------------------------------------------------------------------
  // APB decode and mode control
  // ----------------------------------------------------------------------
  otm_pkg::otm_mode_e mode_r;
  logic [3:0] rs_cnt_r;
  wire logic wr = psel & penable & pwrite;
  wire logic run = (mode_r == otm_pkg::MODE_RUN);
  wire logic cfg = (mode_r == otm_pkg::MODE_CFG);
  wire logic in_sp = (paddr >= otm_pkg::OFF_SETP0) && (paddr < otm_pkg::OFF_OPTIONS);
  wire logic [2:0] sp_idx = 3'((paddr - otm_pkg::OFF_SETP0) >> 2);
  wire logic [2:0] sel = pwdata[otm_pkg::SEL_LSB +: 3];
  wire logic sel_ok = sel < 3'(otm_pkg::SP_NUM);
  wire logic ctl_wr = wr && paddr == otm_pkg::OFF_CTRL;
  wire logic rst_cmd = (rst_s_r[1] & ~rst_d_r) | (ctl_wr & pwdata[otm_pkg::CTRL_RESET]);
  wire logic unmapped = !(paddr[1:0] == 2'h0 && paddr <= otm_pkg::OFF_TRIM);
  assign pready = 1'b1;
  assign pslverr = psel & penable & unmapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= otm_pkg::MODE_RUN;
      rs_cnt_r <= 4'h0;
    end else begin
      unique case (mode_r)
        otm_pkg::MODE_RUN: if (ctl_wr && pwdata[otm_pkg::CTRL_CFG_ENTER]) mode_r <= otm_pkg::MODE_CFG;
        otm_pkg::MODE_CFG: if (ctl_wr && pwdata[otm_pkg::CTRL_CFG_EXIT]) mode_r <= otm_pkg::MODE_STORE;
        otm_pkg::MODE_STORE: begin
          mode_r <= otm_pkg::MODE_RESTART;
          rs_cnt_r <= 4'h0;
        end
        otm_pkg::MODE_RESTART: begin
          rs_cnt_r <= rs_cnt_r + 4'h1;
          if (rs_cnt_r == 4'(otm_pkg::RESTART_CYCLES - 1)) mode_r <= otm_pkg::MODE_RUN;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // Setpoints, nonvolatile copy and password window
  // ----------------------------------------------------------------------
  logic [15:0] sp_r [otm_pkg::SP_NUM];
  logic [15:0] nv_r [otm_pkg::SP_NUM];
  logic [1:0] opt_r, nv_opt_r;
  logic [15:0] trim_r, nv_trim_r;
  logic [31:0] pw_cnt_r;
  logic dirty_r;
  wire logic pw_open = (pw_cnt_r != 32'h0);
  wire logic [15:0] step = pwdata[otm_pkg::ADJ_FAST] ? otm_pkg::STEP_FAST : otm_pkg::STEP_SLOW;
  wire logic save = (ctl_wr && pwdata[otm_pkg::CTRL_SAVE]) || mode_r == otm_pkg::MODE_STORE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < otm_pkg::SP_NUM; i++) begin
        sp_r[i] <= (i == 0) ? otm_pkg::RST_OVS : (i == 1) ? otm_pkg::RST_FAIL :
                   (i == 4) ? otm_pkg::RST_WINDOW : otm_pkg::RST_TEETH;
        nv_r[i] <= (i == 0) ? otm_pkg::RST_OVS : (i == 1) ? otm_pkg::RST_FAIL :
                   (i == 4) ? otm_pkg::RST_WINDOW : otm_pkg::RST_TEETH;
      end
      opt_r <= otm_pkg::RST_OPTIONS;
      nv_opt_r <= otm_pkg::RST_OPTIONS;
      trim_r <= 16'h0;
      nv_trim_r <= 16'h0;
      dirty_r <= 1'b0;
    end else if (mode_r == otm_pkg::MODE_RESTART) begin
      // Restart reloads the stored copy, so anything not saved is lost.
      for (int i = 0; i < otm_pkg::SP_NUM; i++) sp_r[i] <= nv_r[i];
      opt_r <= nv_opt_r;
      trim_r <= nv_trim_r;
      dirty_r <= 1'b0;
    end else if (save) begin
      for (int i = 0; i < otm_pkg::SP_NUM; i++) nv_r[i] <= sp_r[i];
      nv_opt_r <= opt_r;
      nv_trim_r <= trim_r;
      dirty_r <= 1'b0;
    end else if (wr) begin
      if (cfg && in_sp) begin
        sp_r[sp_idx] <= pwdata[15:0];
        dirty_r <= 1'b1;
      end else if (cfg && paddr == otm_pkg::OFF_OPTIONS) begin
        opt_r <= pwdata[1:0];
        dirty_r <= 1'b1;
      end else if (paddr == otm_pkg::OFF_ADJUST && sel_ok) begin
        if (pwdata[otm_pkg::ADJ_UP] && sp_r[sel] <= 16'hffff - step) sp_r[sel] <= sp_r[sel] + step;
        else if (pwdata[otm_pkg::ADJ_DOWN] && sp_r[sel] >= step) sp_r[sel] <= sp_r[sel] - step;
        dirty_r <= 1'b1;
      end else if (paddr == otm_pkg::OFF_EXACT && sel_ok && within_ten(pwdata[15:0], sp_r[sel])) begin
        sp_r[sel] <= pwdata[15:0];
        dirty_r <= 1'b1;
      end else if (paddr == otm_pkg::OFF_TRIM && pw_open) begin
        // Trim is a protected service item, limited to plus or minus its span.
        if ($signed(pwdata[15:0]) <= $signed(otm_pkg::TRIM_MAX) && $signed(pwdata[15:0]) >= -$signed(otm_pkg::TRIM_MAX)) begin
          trim_r <= pwdata[15:0];
          dirty_r <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pw_cnt_r <= 32'h0;
    else if (wr && paddr == otm_pkg::OFF_PASSWORD && pwdata[15:0] == PASSWORD) pw_cnt_r <= 32'(PW_MS);
    else if (tick_r && pw_open) pw_cnt_r <= pw_cnt_r - 32'h1;
  end
  // ----------------------------------------------------------------------
  // Speed measurement
  // ----------------------------------------------------------------------
  logic [15:0] cnt1_r, cnt2_r, spd1_r, spd2_r, gate_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt1_r <= 16'h0;
      cnt2_r <= 16'h0;
      spd1_r <= 16'h0;
      spd2_r <= 16'h0;
      gate_r <= 16'h0;
    end else if (tick_r && gate_r == 16'(GATE_MS - 1)) begin
      spd1_r <= rpm_calc(cnt1_r, sp_r[otm_pkg::SP_TEETH1]);
      spd2_r <= rpm_calc(cnt2_r, sp_r[otm_pkg::SP_TEETH2]);
      cnt1_r <= 16'(pu1_edge);
      cnt2_r <= 16'(pu2_edge);
      gate_r <= 16'h0;
    end else begin
      if (pu1_edge && cnt1_r != 16'hffff) cnt1_r <= cnt1_r + 16'h1;
      if (pu2_edge && cnt2_r != 16'hffff) cnt2_r <= cnt2_r + 16'h1;
      if (tick_r) gate_r <= gate_r + 16'h1;
    end
  end
  // ----------------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------------
  // The terminal presence pin is only reported; no protection term reads it.
  logic [16:0] fail_lvl;
  logic ovs_r, both_r, lost1_r, lost2_r;
  logic [15:0] flash_cnt_r;
  logic flash_r;
  wire logic [15:0] hss = (spd1_r > spd2_r) ? spd1_r : spd2_r;
  wire logic lost1 = {1'b0, spd1_r} < fail_lvl;
  wire logic lost2 = {1'b0, spd2_r} < fail_lvl;
  wire logic [16:0] win = 17'(sp_r[otm_pkg::SP_WINDOW]);
  wire logic hi1 = (opt_r[otm_pkg::OPT_DIFF_EN] && 17'(spd1_r) > 17'(spd2_r) + win) || lost2_r;
  wire logic hi2 = (opt_r[otm_pkg::OPT_DIFF_EN] && 17'(spd2_r) > 17'(spd1_r) + win) || lost1_r;
  wire logic trip = ovs_r || (both_r && opt_r[otm_pkg::OPT_TRIP_BOTH]);
  always_comb begin
    fail_lvl = 17'(sp_r[otm_pkg::SP_FAIL]) + {trim_r[15], trim_r};
    if (fail_lvl[16]) fail_lvl = 17'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovs_r <= 1'b0;
    else if (!run) ovs_r <= 1'b0;
    else if (hss >= sp_r[otm_pkg::SP_OVS]) ovs_r <= 1'b1;
    else if (rst_cmd) ovs_r <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      both_r <= 1'b0;
      lost1_r <= 1'b0;
      lost2_r <= 1'b0;
    end else if (!run) begin
      both_r <= 1'b0;
      lost1_r <= 1'b0;
      lost2_r <= 1'b0;
    end else begin
      // Override suppresses new failsafe events; a new event beats a reset.
      if (lost1 && lost2 && !override) both_r <= 1'b1;
      else if (rst_cmd && override) both_r <= 1'b0;
      if (lost1 && !override) lost1_r <= 1'b1;
      else if (rst_cmd && (!lost1 || override)) lost1_r <= 1'b0;
      if (lost2 && !override) lost2_r <= 1'b1;
      else if (rst_cmd && (!lost2 || override)) lost2_r <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_r <= 16'h0;
      flash_r <= 1'b0;
    end else if (tick_r) begin
      if (flash_cnt_r == 16'(otm_pkg::FLASH_MS - 1)) begin
        flash_cnt_r <= 16'h0;
        flash_r <= ~flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 16'h1;
      end
    end
  end
  // Relays are energized-healthy, so a shut-down output stage opens them all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_relay <= 1'b0;
      fail1_relay <= 1'b0;
      fail2_relay <= 1'b0;
      lamp1 <= 1'b0;
      lamp2 <= 1'b0;
    end else begin
      trip_relay <= run && !trip;
      fail1_relay <= run && !(lost1_r || lost2_r || hi1);
      fail2_relay <= run && !(lost1_r || lost2_r || hi2);
      lamp1 <= run && (ovs_r ? flash_r : (both_r || lost1_r || lost2_r));
      lamp2 <= run && (ovs_r ? flash_r : (both_r || lost1_r || lost2_r));
    end
  end
  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (in_sp) prdata <= {16'h0, sp_r[sp_idx]};
      else if (paddr == otm_pkg::OFF_STATUS)
        prdata <= {19'h0, term_s_r[1], ovr_s_r[1], dirty_r, pw_open, 2'(mode_r),
                   hi2, hi1, both_r, lost2_r, lost1_r, ovs_r, trip};
      else if (paddr == otm_pkg::OFF_SPEED1) prdata <= {16'h0, spd1_r};
      else if (paddr == otm_pkg::OFF_SPEED2) prdata <= {16'h0, spd2_r};
      else if (paddr == otm_pkg::OFF_OPTIONS) prdata <= {30'h0, opt_r};
      else if (paddr == otm_pkg::OFF_TRIM && pw_open) prdata <= {16'h0, trim_r};
    end
  end
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_trip_open;
    @(posedge pclk) disable iff (!presetn) ovs_r |=> !trip_relay;
  endproperty
  a_trip_open: assert property (p_trip_open) else $error("trip relay closed during overspeed");
  property p_ovs_hold;
    @(posedge pclk) disable iff (!presetn) ovs_r && run && !rst_cmd ##1 run |-> ovs_r;
  endproperty
  a_ovs_hold: assert property (p_ovs_hold) else $error("overspeed cleared without reset");
  property p_both_steady;
    @(posedge pclk) disable iff (!presetn) run && both_r && !ovs_r ##1 run |-> lamp1 && lamp2;
  endproperty
  a_both_steady: assert property (p_both_steady) else $error("lamps not steady on dual failure");
  property p_both_clear;
    @(posedge pclk) disable iff (!presetn) $fell(both_r) |-> $past(override) || $past(!run);
  endproperty
  a_both_clear: assert property (p_both_clear) else $error("dual failure cleared without override");
  property p_lost_relays;
    @(posedge pclk) disable iff (!presetn) (lost1_r || lost2_r) |=> !fail1_relay && !fail2_relay;
  endproperty
  a_lost_relays: assert property (p_lost_relays) else $error("pickup relay closed with pickup lost");
  property p_lost_hold;
    @(posedge pclk) disable iff (!presetn) lost1_r && lost1 && run && !override |=> lost1_r || !run;
  endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("pickup alarm cleared while lost");
  property p_cfg_dark;
    @(posedge pclk) disable iff (!presetn) cfg |=> !trip_relay && !fail1_relay && !fail2_relay;
  endproperty
  a_cfg_dark: assert property (p_cfg_dark) else $error("outputs live in configuration");
  property p_exit_store;
    @(posedge pclk) disable iff (!presetn)
      mode_r == otm_pkg::MODE_STORE |=> mode_r == otm_pkg::MODE_RESTART ##8 mode_r == otm_pkg::MODE_RUN;
  endproperty
  a_exit_store: assert property (p_exit_store) else $error("store and restart sequence broken");
  property p_fast_step;
    @(posedge pclk) disable iff (!presetn)
      wr && (run || cfg) && paddr == otm_pkg::OFF_ADJUST && pwdata[2:0] == 3'h5 && sel == 3'h4 && sp_r[4] < 16'hff00
      |=> sp_r[4] == $past(sp_r[4]) + 16'h000a;
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast step wrong");
  property p_pw_gate;
    @(posedge pclk) disable iff (!presetn) !pw_open && !save && run |=> trim_r == $past(trim_r);
  endproperty
  a_pw_gate: assert property (p_pw_gate) else $error("trim changed without password");
  c_overspeed: cover property (@(posedge pclk) disable iff (!presetn) $rose(ovs_r));
  c_dual_fail: cover property (@(posedge pclk) disable iff (!presetn) $rose(both_r));
  c_restart: cover property (@(posedge pclk) disable iff (!presetn) mode_r == otm_pkg::MODE_RESTART);
endmodule // otm_top

/* File: bench/otm_pickups.sv */
// Both pickups step on one shared tick so equal rates stay in phase.
// Edges fall at the same instants as rising clock edges, so the synchroniser samples them in a race.
module otm_pickups (
  input int half1,
  input int half2,
  output logic p1,
  output logic p2
);
  timeunit 1ns;
  timeprecision 1ns;
  int t;
  initial begin
    t = 0;
    p1 = 1'b0;
    p2 = 1'b0;
    #50;
    forever begin
      t++;
      if (half1 > 0 && t % half1 == 0) p1 = ~p1;
      if (half2 > 0 && t % half2 == 0) p2 = ~p2;
      #100;
    end
  end
endmodule // otm_pickups

/* File: bench/otm_top_tb.sv */
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module otm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PW = 16'h0123; // Arbitrary value.
  localparam logic [7:0] A_WIN = otm_pkg::OFF_SETP0 + 8'h10;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, s;
  logic pready, pslverr, er, sp1, sp2;
  logic reset_in = 1'b0, override_in = 1'b0, terminal_present = 1'b0;
  logic trip_relay, fail1_relay, fail2_relay, lamp1, lamp2;
  logic [4:0] outs;
  int h1 = 0, h2 = 0, checks = 0, num_errors = 0;
  assign outs = {trip_relay, fail1_relay, fail2_relay, lamp1, lamp2};
  always #50 pclk = ~pclk;
  otm_pickups u_pick (.half1(h1), .half2(h2), .p1(sp1), .p2(sp2));
  otm_top #(.TICK_CYCLES(10), .PW_MS(50), .GATE_MS(4), .PASSWORD(PW)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_pickup1(sp1), .speed_pickup2(sp2), .reset_in(reset_in), .override_in(override_in),
    .terminal_present(terminal_present), .trip_relay(trip_relay), .fail1_relay(fail1_relay),
    .fail2_relay(fail2_relay), .lamp1(lamp1), .lamp2(lamp2));
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask
  // The reset contact is closed only briefly, as the plant does.
  task automatic pulse_reset();
    reset_in <= 1'b1;
    cyc(4);
    reset_in <= 1'b0;
    cyc(8);
  endtask
  task automatic watch(output int n);
    logic l;
    n = 0;
    l = lamp1;
    repeat (3000) begin
      @(posedge pclk);
      if (lamp1 !== l) n++;
      l = lamp1;
    end
  endtask
  initial begin
    #6000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    int n;
    logic [4:0] o;
    cyc(12);
    presetn <= 1'b1;
    cyc(100);
    `CHK(outs, 5'h03)
    rdchk(otm_pkg::OFF_STATUS, 32'h1c, 32'h1c);
    watch(n);
    `CHK(n, 0)
    pulse_reset();
    `CHK(outs, 5'h03)
    override_in <= 1'b1;
    pulse_reset();
    `CHK(outs, 5'h1c)
    h1 = 4;
    h2 = 4;
    cyc(200);
    override_in <= 1'b0;
    cyc(100);
    `CHK(outs, 5'h1c)
    apb(1'b0, otm_pkg::OFF_SPEED1, 32'h0);
    s = rd;
    rdchk(otm_pkg::OFF_SPEED2, 32'hffffffff, s);
    `CHK(s >= 2000 && s <= 3000, 1'b1)
    h1 = 2;
    cyc(200);
    `CHK(outs[4:2], 3'h5)
    rdchk(otm_pkg::OFF_STATUS, 32'h60, 32'h20);
    h1 = 4;
    h2 = 0;
    cyc(200);
    `CHK(outs, 5'h13)
    rdchk(otm_pkg::OFF_STATUS, 32'h68, 32'h28);
    pulse_reset();
    rdchk(otm_pkg::OFF_STATUS, 32'h8, 32'h8);
    h2 = 4;
    cyc(200);
    pulse_reset();
    `CHK(outs, 5'h1c)
    h1 = 1;
    cyc(200);
    `CHK(trip_relay, 1'b0)
    watch(n);
    `CHK(n > 0, 1'b1)
    pulse_reset();
    `CHK(trip_relay, 1'b0)
    h1 = 4;
    cyc(200);
    `CHK(trip_relay, 1'b0)
    pulse_reset();
    `CHK(trip_relay, 1'b1)
    o = outs;
    terminal_present <= 1'b1;
    cyc(50);
    terminal_present <= 1'b0;
    cyc(50);
    `CHK(outs, o)
    wr(A_WIN, 32'h64);
    rdchk(A_WIN, 32'hffff, 32'hc8);
    wr(otm_pkg::OFF_CTRL, 32'h4);
    cyc(4);
    `CHK(outs, 5'h00)
    rdchk(otm_pkg::OFF_STATUS, 32'h180, 32'h80);
    wr(otm_pkg::OFF_ADJUST, 32'h40001);
    rdchk(A_WIN, 32'hffff, 32'hc9);
    wr(otm_pkg::OFF_ADJUST, 32'h40005);
    rdchk(A_WIN, 32'hffff, 32'hd3);
    wr(otm_pkg::OFF_EXACT, 32'h400e8);
    rdchk(A_WIN, 32'hffff, 32'he8);
    wr(otm_pkg::OFF_EXACT, 32'h4012c);
    rdchk(A_WIN, 32'hffff, 32'he8);
    wr(otm_pkg::OFF_ADJUST, 32'h40006);
    rdchk(A_WIN, 32'hffff, 32'hde);
    wr(otm_pkg::OFF_OPTIONS, 32'h2);
    wr(otm_pkg::OFF_CTRL, 32'h8);
    cyc(20);
    rdchk(otm_pkg::OFF_STATUS, 32'h580, 32'h0);
    rdchk(A_WIN, 32'hffff, 32'hde);
    rdchk(otm_pkg::OFF_OPTIONS, 32'h3, 32'h2);
    wr(otm_pkg::OFF_TRIM, 32'h5);
    rdchk(otm_pkg::OFF_TRIM, 32'hffff, 32'h0);
    wr(otm_pkg::OFF_PASSWORD, {16'h0, PW});
    rdchk(otm_pkg::OFF_STATUS, 32'h200, 32'h200);
    wr(otm_pkg::OFF_TRIM, 32'h5);
    rdchk(otm_pkg::OFF_TRIM, 32'hffff, 32'h5);
    cyc(400);
    rdchk(otm_pkg::OFF_STATUS, 32'h200, 32'h200);
    cyc(200);
    rdchk(otm_pkg::OFF_STATUS, 32'h200, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    wr(otm_pkg::OFF_EXACT, 32'h400f0);
    rdchk(otm_pkg::OFF_STATUS, 32'h400, 32'h400);
    wr(otm_pkg::OFF_CTRL, 32'h2);
    rdchk(otm_pkg::OFF_STATUS, 32'h400, 32'h0);
    rdchk(A_WIN, 32'hffff, 32'hf0);
    // With trip-on-dual cleared in configuration, a dual loss only alarms.
    h1 = 0;
    h2 = 0;
    cyc(200);
    `CHK(outs, 5'h13)
    override_in <= 1'b1;
    cyc(8);
    wr(otm_pkg::OFF_CTRL, 32'h1);
    cyc(4);
    `CHK(outs, 5'h1c)
    tally_and_finish();
  end
endmodule // otm_top_tb
